// [hdl/txy_pkg.sv]
package txy_pkg;
   // operating mode field values, bits 2..0 of a timer mode register
   localparam logic [2:0] TXY_MODE_PULSE_OUT = 3'h1;
   localparam logic [2:0] TXY_MODE_PERIOD = 3'h2;
   localparam logic [2:0] TXY_MODE_WIDTH = 3'h3;
   localparam logic [2:0] TXY_MODE_WAVE = 3'h4;
   localparam logic [2:0] TXY_MODE_ONE_SHOT = 3'h5;
   // mode register field positions
   localparam int TXY_MODE_LSB = 0;
   localparam int TXY_WRITE_LATCH_ONLY_BIT = 3;
   localparam int TXY_OUT_LATCH_BIT = 4;
   localparam int TXY_TRIG_SEL_BIT = 5;
   // edge polarity register bit positions
   localparam int TXY_EG_TRIG_X_BIT = 0;
   localparam int TXY_EG_TRIG_Y_BIT = 1;
   localparam int TXY_EG_PIN_X_BIT = 2;
   localparam int TXY_EG_PIN_Y_BIT = 3;
   // second interrupt request register bit positions
   localparam int TXY_IRQ2_TRIG_X_BIT = 0;
   localparam int TXY_IRQ2_TRIG_Y_BIT = 1;
   localparam int TXY_IRQ2_MEAS_X_BIT = 2;
   localparam int TXY_IRQ2_MEAS_Y_BIT = 3;
   // count source select encoding
   localparam logic [1:0] TXY_SRC_DIV2 = 2'h0;
   localparam logic [1:0] TXY_SRC_DIV8 = 2'h1;
   localparam logic [1:0] TXY_SRC_DIV16 = 2'h2;
   localparam int TXY_PRESCALE_W = 4;
   // reset values and the all-ones measurement reload value
   localparam logic [1:0] TXY_STOP_RESET = 2'h3;
   localparam logic [15:0] TXY_COUNT_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] TXY_COUNT_ZERO = 16'h0000;
   localparam logic [7:0] TXY_MODE_RESET = 8'h00;
   localparam logic [3:0] TXY_EG_RESET = 4'h0;

   typedef struct packed {
      logic [7:0] mode;
      logic [1:0] src_sel;
      logic pin_pol;
      logic trig_pol;
      logic stop;
   } txy_cfg_t;

   typedef struct packed {
      logic wr;
      logic [15:0] data;
   } txy_wr_t;
endpackage : txy_pkg

// [hdl/txy_prescaler.sv]
`timescale 1ns/1ns
module txy_prescaler
   import txy_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   output logic tick2,
   output logic tick8,
   output logic tick16
);
   logic [TXY_PRESCALE_W-1:0] div;

   // one free-running divider serves both timers and all three rates
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= '0;
      end else begin
         div <= div + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick2 <= 1'b0;
         tick8 <= 1'b0;
         tick16 <= 1'b0;
      end else begin
         tick2 <= div[0];
         tick8 <= (div[2:0] == 3'h7);
         tick16 <= (div == 4'hF);
      end
   end
endmodule : txy_prescaler

// [hdl/txy_edge_detect.sv]
`timescale 1ns/1ns
module txy_edge_detect (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic level,
   output logic rise,
   output logic fall
);
   logic prev;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule : txy_edge_detect

// [hdl/txy_timer.sv]
// Contract
// - count clock is main clock divided by 2, 8 or 16
// - mode 001 is pulse output: pin toggles on underflow, underflow request
// - pulse output starts high when pin polarity 0, low when 1
// - pulse output, stopped: counter write sets pin from pin polarity
// - pulse output, running: pin polarity change inverts pin immediately
// - mode 010 period: polarity 0 falling-to-falling, 1 rising-to-rising
// - period edge: latch gets complement of count, counter gets all ones
// - mode 011 width: polarity 1 low phase, 0 high phase
// - width: completing edge latches complement; both edges load all ones
// - measurement done raises measurement request bit per timer
// - measurement underflow raises interrupt, reloads all ones; result held
// - measurement: count unreadable, latch read-only while running, preset only stopped
// - mode 100 waveform: pin takes output latch bit at each underflow
// - waveform with trigger select and running: trigger edge starts count
// - trigger polarity 0 falling, 1 rising; edge raises trigger request
// - mode 101 one-shot: stopped ignores triggers; software loads width
// - one-shot polarity 0: pin low on select, high on trigger, low at end
// - one-shot polarity 1: pin high on select, low on trigger, high at end
// - one-shot pin polarity change flips pin level
// - stop bit resets to 1; writing 0 starts counting
// - decrement per pulse; pulse after zero underflows and reloads latch outside measurement
`timescale 1ns/1ns
module txy_timer
   import txy_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] timer_x_mode_register,
   input wire logic [7:0] timer_y_mode_register,
   input wire logic [1:0] timer_x_src_sel,
   input wire logic [1:0] timer_y_src_sel,
   input wire logic [3:0] edge_polarity_select,
   input wire logic [1:0] stop_wr_data,
   input wire logic stop_wr,
   input wire logic [1:0] count_wr,
   input wire logic [15:0] count_wr_data,
   input wire logic timer_x_io_pin_in,
   input wire logic timer_y_io_pin_in,
   input wire logic timer_x_trigger_pin,
   input wire logic timer_y_trigger_pin,
   output logic [1:0] timer_pair_stop_control,
   output logic [15:0] timer_x_count,
   output logic [15:0] timer_y_count,
   output logic [1:0] count_readable,
   output logic [15:0] timer_x_latch,
   output logic [15:0] timer_y_latch,
   output logic timer_x_io_pin_out,
   output logic timer_x_io_pin_oe,
   output logic timer_y_io_pin_out,
   output logic timer_y_io_pin_oe,
   output logic [1:0] underflow_request,
   output logic [3:0] interrupt_request_second
);
   logic tick2;
   logic tick8;
   logic tick16;
   logic [1:0] stop;

   txy_prescaler u_pre (
      .clk(clk),
      .rst_n(rst_n),
      .tick2(tick2),
      .tick8(tick8),
      .tick16(tick16)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop <= TXY_STOP_RESET;
      end else if (stop_wr) begin
         stop <= stop_wr_data;
      end
   end
   assign timer_pair_stop_control = stop;

   logic [7:0] mode_v [2];
   logic [1:0] src_v [2];
   logic pin_in_v [2];
   logic trig_in_v [2];
   logic [15:0] count_v [2];
   logic [15:0] latch_v [2];
   logic pin_out_v [2];
   logic pin_oe_v [2];
   logic [1:0] irq2_trig;
   logic [1:0] irq2_meas;

   assign mode_v[0] = timer_x_mode_register;
   assign mode_v[1] = timer_y_mode_register;
   assign src_v[0] = timer_x_src_sel;
   assign src_v[1] = timer_y_src_sel;
   assign pin_in_v[0] = timer_x_io_pin_in;
   assign pin_in_v[1] = timer_y_io_pin_in;
   assign trig_in_v[0] = timer_x_trigger_pin;
   assign trig_in_v[1] = timer_y_trigger_pin;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         logic [2:0] op;
         logic pin_pol;
         logic trig_pol;
         logic pin_pol_q;
         logic [2:0] op_q;
         logic tick;
         logic pin_rise;
         logic pin_fall;
         logic trg_rise;
         logic trg_fall;
         logic trig_edge;
         logic pin_edge_act;
         logic pin_edge_done;
         logic measuring;
         logic in_phase;
         logic armed;
         logic running;
         logic uflow;
         logic is_meas;
         logic [15:0] count;
         logic [15:0] latch;
         logic pin;

         assign op = mode_v[g][TXY_MODE_LSB +: 3];
         assign pin_pol = edge_polarity_select[TXY_EG_PIN_X_BIT + g];
         assign trig_pol = edge_polarity_select[TXY_EG_TRIG_X_BIT + g];
         assign is_meas = (op == TXY_MODE_PERIOD) || (op == TXY_MODE_WIDTH);

         always_comb begin
            unique case (src_v[g])
               TXY_SRC_DIV2: tick = tick2;
               TXY_SRC_DIV8: tick = tick8;
               TXY_SRC_DIV16: tick = tick16;
               default: tick = tick16;
            endcase
         end

         txy_edge_detect u_pin (
            .clk(clk),
            .rst_n(rst_n),
            .level(pin_in_v[g]),
            .rise(pin_rise),
            .fall(pin_fall)
         );

         txy_edge_detect u_trg (
            .clk(clk),
            .rst_n(rst_n),
            .level(trig_in_v[g]),
            .rise(trg_rise),
            .fall(trg_fall)
         );

         assign trig_edge = trig_pol ? trg_rise : trg_fall;
         // active pin edges; width starts on one edge, ends on the other
         assign pin_edge_done = (op == TXY_MODE_PERIOD) ?
            (pin_pol ? pin_rise : pin_fall) : (pin_pol ? pin_rise : pin_fall);
         assign pin_edge_act = (op == TXY_MODE_PERIOD) ? pin_edge_done :
            (in_phase ? pin_edge_done : (pin_pol ? pin_fall : pin_rise));

         // waveform gated by trigger needs an arming edge; one-shot waits too
         assign running = !stop[g] && !armed;
         // underflow on the pulse after zero
         assign uflow = running && tick && (count == TXY_COUNT_ZERO);

         // waveform/one-shot trigger gate; waiting state re-arms on stop
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               armed <= 1'b0;
            end else if (stop[g]) begin
               armed <= (op == TXY_MODE_ONE_SHOT) ||
                  ((op == TXY_MODE_WAVE) && mode_v[g][TXY_TRIG_SEL_BIT]);
            end else if (trig_edge) begin
               armed <= 1'b0;
            end else if (uflow && (op == TXY_MODE_ONE_SHOT)) begin
               armed <= 1'b1;
            end
         end

         assign measuring = is_meas && !stop[g];

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               in_phase <= 1'b0;
            end else if (!measuring || (op != TXY_MODE_WIDTH)) begin
               in_phase <= 1'b0;
            end else if (pin_edge_act) begin
               in_phase <= ~in_phase;
            end
         end

         // counter
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               count <= TXY_COUNT_ZERO;
            end else if (measuring && pin_edge_act) begin
               // all ones on each active edge
               count <= TXY_COUNT_ALL_ONES;
            end else if (uflow) begin
               // measurement reload is all ones, else latch
               count <= is_meas ? TXY_COUNT_ALL_ONES : latch;
            end else if (count_wr[g] && (stop[g] || !is_meas) &&
                         !mode_v[g][TXY_WRITE_LATCH_ONLY_BIT]) begin
               // preset outside measurement modes except on underflow, only while stopped in them; never with write-latch-only set
               count <= count_wr_data;
            end else if (running && tick) begin
               count <= count - 16'h0001;
            end
         end

         // reload latch
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               latch <= TXY_COUNT_ZERO;
            end else if (measuring && pin_edge_act &&
                         ((op == TXY_MODE_PERIOD) || in_phase)) begin
               latch <= ~count;
            end else if (count_wr[g] && !measuring) begin
               latch <= count_wr_data;
            end
         end

         // pin output
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pin <= 1'b0;
               pin_pol_q <= 1'b0;
               op_q <= 3'h0;
            end else begin
               pin_pol_q <= pin_pol;
               op_q <= op;
               unique case (op)
                  TXY_MODE_PULSE_OUT: begin
                     if (op_q != op) begin
                        pin <= ~pin_pol;
                     end else if (stop[g] && count_wr[g]) begin
                        pin <= ~pin_pol;
                     end else begin
                        // both inversions apply, so a change at underflow cancels out
                        pin <= pin ^ (!stop[g] && (pin_pol != pin_pol_q)) ^ uflow;
                     end
                  end
                  TXY_MODE_WAVE: begin
                     if (uflow) begin
                        pin <= mode_v[g][TXY_OUT_LATCH_BIT];
                     end
                  end
                  TXY_MODE_ONE_SHOT: begin
                     if (op_q != op) begin
                        // idle level on select; armed lags the mode by a cycle
                        pin <= pin_pol;
                     end else if (pin_pol != pin_pol_q) begin
                        pin <= armed ? pin_pol : ~pin;
                     end else if (!stop[g] && armed && trig_edge) begin
                        pin <= ~pin_pol;
                     end else if (uflow) begin
                        pin <= pin_pol;
                     end
                  end
                  default: pin <= pin;
               endcase
            end
         end

         assign pin_oe_v[g] = (op == TXY_MODE_PULSE_OUT) || (op == TXY_MODE_WAVE) ||
            (op == TXY_MODE_ONE_SHOT);
         assign pin_out_v[g] = pin;
         assign count_v[g] = count;
         assign latch_v[g] = latch;
         assign count_readable[g] = !is_meas;
         assign underflow_request[g] = uflow;
         // trigger request in waveform and one-shot
         assign irq2_trig[g] = trig_edge &&
            ((op == TXY_MODE_WAVE) || (op == TXY_MODE_ONE_SHOT));
         assign irq2_meas[g] = measuring && pin_edge_act &&
            ((op == TXY_MODE_PERIOD) || in_phase);
      end
   endgenerate

   assign timer_x_count = count_v[0];
   assign timer_y_count = count_v[1];
   assign timer_x_latch = latch_v[0];
   assign timer_y_latch = latch_v[1];
   assign timer_x_io_pin_out = pin_out_v[0];
   assign timer_y_io_pin_out = pin_out_v[1];
   assign timer_x_io_pin_oe = pin_oe_v[0];
   assign timer_y_io_pin_oe = pin_oe_v[1];
   assign interrupt_request_second[TXY_IRQ2_TRIG_X_BIT] = irq2_trig[0];
   assign interrupt_request_second[TXY_IRQ2_TRIG_Y_BIT] = irq2_trig[1];
   assign interrupt_request_second[TXY_IRQ2_MEAS_X_BIT] = irq2_meas[0];
   assign interrupt_request_second[TXY_IRQ2_MEAS_Y_BIT] = irq2_meas[1];
endmodule : txy_timer

// [test/txy_partner.sv]
`timescale 1ns/1ns
module txy_partner (
   input wire logic clk,
   input wire logic [1:0] drv_oe,
   input wire logic [1:0] drv_out,
   input wire logic [7:0] hi_len,
   input wire logic [7:0] lo_len,
   output wire logic [1:0] pin
);
   logic [7:0] cnt = 8'h00;
   logic wave = 1'b0;
   // asymmetric so high and low phases measure apart
   always @(posedge clk) begin
      if (cnt + 8'h01 >= (wave ? hi_len : lo_len)) begin
         wave <= !wave;
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   assign pin = (drv_oe & drv_out) | (~drv_oe & {2{wave}});
endmodule : txy_partner

// [test/txy_chk.sv]
`timescale 1ns/1ns
module txy_chk
   import txy_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] timer_x_mode_register,
   input wire logic [3:0] edge_polarity_select,
   input wire logic stop_wr,
   input wire logic [1:0] stop_wr_data,
   input wire logic [1:0] count_wr,
   input wire logic [1:0] timer_pair_stop_control,
   input wire logic [15:0] timer_x_count,
   input wire logic [1:0] count_readable,
   input wire logic [15:0] timer_x_latch,
   input wire logic timer_x_io_pin_out,
   input wire logic [1:0] underflow_request,
   input wire logic [3:0] interrupt_request_second
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] md;
   logic meas;
   logic uf;
   assign md = timer_x_mode_register[2:0];
   assign meas = md == TXY_MODE_PERIOD || md == TXY_MODE_WIDTH;
   assign uf = underflow_request[0];
   a_stop_write: assert property (stop_wr |=> timer_pair_stop_control == $past(stop_wr_data))
      else $error("stop bits not written");
   a_stop_holds: assert property (timer_pair_stop_control[0] && !count_wr[0] |=>
      $stable(timer_x_count)) else $error("stopped count moved");
   a_uf_zero: assert property (uf |-> timer_x_count == TXY_COUNT_ZERO)
      else $error("underflow off zero");
   a_uf_reload: assert property (uf && !meas && !count_wr[0] |=>
      timer_x_count == $past(timer_x_latch)) else $error("reload wrong");
   a_meas_reload: assert property (uf && meas |=> timer_x_count == TXY_COUNT_ALL_ONES)
      else $error("measure reload wrong");
   a_pulse_flip: assert property (uf && md == TXY_MODE_PULSE_OUT && !count_wr[0] &&
      $stable(edge_polarity_select) |=> timer_x_io_pin_out != $past(timer_x_io_pin_out))
      else $error("pulse pin not toggled");
   a_wave_level: assert property (uf && md == TXY_MODE_WAVE |=>
      timer_x_io_pin_out == $past(timer_x_mode_register[TXY_OUT_LATCH_BIT]))
      else $error("wave level wrong");
   a_meas_latch: assert property (interrupt_request_second[2] |-> meas ##1
      timer_x_latch == ~$past(timer_x_count)) else $error("measure latch wrong");
   a_count_hidden: assert property (count_readable[0] == !meas)
      else $error("readable flag wrong");
   cover property (uf && md == TXY_MODE_PULSE_OUT);
   cover property (interrupt_request_second[2]);
   cover property (interrupt_request_second[0]);
endmodule : txy_chk
bind txy_timer txy_chk i_txy_chk (.*);

// [test/txy_timer_tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: %0h %0h", $time, a, b); end end
module txy_timer_tb_top
   import txy_pkg::*;
;
   typedef struct packed {
      logic [1:0] src;
      logic [15:0] lat;
      logic pol;
      logic [7:0] ivl;
   } txy_row_t;
   // expected underflow spacing is divider times (latch + 1)
   localparam txy_row_t ROWS [4] = '{'{TXY_SRC_DIV2, 16'h0003, 1'b0, 8'h08},
      '{TXY_SRC_DIV8, 16'h0001, 1'b1, 8'h10}, '{TXY_SRC_DIV16, 16'h0000, 1'b0, 8'h10},
      '{2'h3, 16'h0002, 1'b1, 8'h30}};
   int checks = 0;
   int n_fail = 0;
   int n, t, e;
   logic p;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0][7:0] mr = 16'h0000;
   logic [1:0][1:0] src = 4'h0;
   logic [3:0] eg = 4'h0;
   logic [1:0] swd = 2'h3;
   logic sw = 1'b0;
   logic [1:0] cw = 2'h0;
   logic [15:0] cwd = 16'h0000;
   logic [1:0] trig = 2'h0;
   wire logic [1:0] pin, stp, rd, po, oe, uf;
   wire logic [1:0][15:0] cnt, lat;
   wire logic [3:0] irq;
   always #5 clk = ~clk;
   txy_timer i_txy_timer (.clk(clk), .rst_n(rst_n), .timer_x_mode_register(mr[0]),
      .timer_y_mode_register(mr[1]), .timer_x_src_sel(src[0]), .timer_y_src_sel(src[1]),
      .edge_polarity_select(eg), .stop_wr_data(swd), .stop_wr(sw), .count_wr(cw),
      .count_wr_data(cwd), .timer_x_io_pin_in(pin[0]), .timer_y_io_pin_in(pin[1]),
      .timer_x_trigger_pin(trig[0]), .timer_y_trigger_pin(trig[1]),
      .timer_pair_stop_control(stp), .timer_x_count(cnt[0]), .timer_y_count(cnt[1]),
      .count_readable(rd), .timer_x_latch(lat[0]), .timer_y_latch(lat[1]),
      .timer_x_io_pin_out(po[0]), .timer_x_io_pin_oe(oe[0]), .timer_y_io_pin_out(po[1]),
      .timer_y_io_pin_oe(oe[1]), .underflow_request(uf), .interrupt_request_second(irq));
   txy_partner i_txy_partner (.clk(clk), .drv_oe(oe), .drv_out(po), .hi_len(8'h14),
      .lo_len(8'h0C), .pin(pin));
   task automatic wr_cnt(input int k, input logic [15:0] v);
      @(posedge clk);
      cw <= 2'h1 << k;
      cwd <= v;
      @(posedge clk);
      cw <= 2'h0;
   endtask : wr_cnt
   task automatic wr_stop(input logic [1:0] v);
      @(posedge clk);
      sw <= 1'b1;
      swd <= v;
      @(posedge clk);
      sw <= 1'b0;
   endtask : wr_stop
   // requests last one cycle, so sample them mid-cycle
   task automatic wait_ev(input int k, output int c);
      logic [5:0] ev;
      c = 0;
      do begin
         @(negedge clk);
         c++;
         ev = {irq, uf};
      end while (ev[k] !== 1'b1 && c < 600);
      // a missed event counts as a failure
      if (ev[k] !== 1'b1) begin
         n_fail++;
      end
   endtask : wait_ev
   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK(stp, 2'h3)
      `CHK(irq, 4'h0)
      foreach (ROWS[i]) begin
         t = i % 2;
         wr_stop(2'h3);
         mr[t] <= {5'h00, TXY_MODE_PULSE_OUT};
         src[t] <= ROWS[i].src;
         eg[TXY_EG_PIN_X_BIT + t] <= ROWS[i].pol;
         wr_cnt(t, ROWS[i].lat);
         @(negedge clk);
         `CHK(po[t], !ROWS[i].pol)
         wr_stop(~(2'h1 << t));
         wait_ev(t, n);
         p = po[t];
         wait_ev(t, n);
         `CHK(n, int'(ROWS[i].ivl))
         `CHK(po[t], !p)
      end
      @(negedge clk);
      p = po[1];
      @(posedge clk);
      eg[TXY_EG_PIN_Y_BIT] <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK(po[1], !p)
      wr_stop(2'h3);
      mr[0] <= {5'h00, TXY_MODE_PERIOD};
      src[0] <= TXY_SRC_DIV2;
      eg <= 4'h4;
      wr_cnt(0, 16'hFFFF);
      `CHK(rd[0], 1'b0)
      wr_stop(2'h2);
      for (int w = 0; w < 3; w++) begin
         if (w > 0) begin
            wr_stop(2'h3);
            mr[0] <= {5'h00, TXY_MODE_WIDTH};
            eg[TXY_EG_PIN_X_BIT] <= w[0];
            wr_stop(2'h2);
         end
         wait_ev(4, n);
         wait_ev(4, n);
         `CHK(n, 32)
         // edge-to-tick phase is not fixed, so allow one count short
         e = (w == 0) ? 16 : ((w == 1) ? 6 : 10);
         @(negedge clk);
         `CHK(lat[0] == e || lat[0] == e - 1, 1'b1)
      end
      wr_stop(2'h3);
      mr[0] <= 8'h34;
      eg <= 4'h1;
      wr_cnt(0, 16'h0003);
      wr_stop(2'h2);
      repeat (20) @(negedge clk);
      `CHK(cnt[0], 16'h0003)
      @(posedge clk);
      trig[0] <= 1'b1;
      wait_ev(2, n);
      `CHK(n < 5, 1'b1)
      wait_ev(0, n);
      @(negedge clk);
      `CHK(po[0], 1'b1)
      @(posedge clk);
      mr[0] <= 8'h24;
      wait_ev(0, n);
      @(negedge clk);
      `CHK(po[0], 1'b0)
      for (int q = 0; q < 2; q++) begin
         wr_stop(2'h3);
         trig[0] <= 1'b1;
         eg <= {1'b0, q[0], 2'h0};
         mr[0] <= {5'h00, TXY_MODE_ONE_SHOT};
         wr_cnt(0, 16'h0002);
         @(posedge clk);
         trig[0] <= 1'b0;
         repeat (4) @(negedge clk);
         `CHK(po[0], q[0])
         @(posedge clk);
         trig[0] <= 1'b1;
         wr_stop(2'h2);
         @(posedge clk);
         trig[0] <= 1'b0;
         repeat (3) @(negedge clk);
         `CHK(po[0], !q[0])
         wait_ev(0, n);
         @(negedge clk);
         `CHK(po[0], q[0])
      end
      // write-latch-only: counter keeps its value, latch takes the write
      wr_stop(2'h3);
      mr[0] <= {5'h01, TXY_MODE_PULSE_OUT};
      wr_cnt(0, 16'h0005);
      @(negedge clk);
      `CHK(cnt[0], 16'h0002)
      `CHK(lat[0], 16'h0005)
      wr_stop(2'h2);
      wait_ev(0, n);
      @(negedge clk);
      `CHK(cnt[0], 16'h0005)
      final_report();
   end
endmodule : txy_timer_tb_top
